// ==== design/btz_pkg.sv ====
/*
 * package for the bit-test skip-when-zero execution block: opcode layout,
 * field positions, phase codes and the access-bank base.
 * assumes a core clock with a four-phase instruction cycle from a divider.
 */
package btz_pkg;
   // ****************************************
   // instruction word layout
   // ****************************************
   localparam logic [3:0] OPC_BIT_TEST_SKIP_WHEN_ZERO = 4'hb;
   localparam int         OPC_MSB    = 15;
   localparam int         OPC_LSB    = 12;
   localparam int         BIT_MSB    = 11;
   localparam int         BIT_LSB    = 9;
   localparam int         ACC_POS    = 8;
   localparam int         ADDR_MSB   = 7;
   localparam int         ADDR_LSB   = 0;
   // access selector value that picks the fixed access bank
   localparam logic       ACC_FIXED  = 1'h0;
   // fixed access bank number, lower half of the access window
   localparam logic [3:0] ACCESS_BANK = 4'h0;
   // ****************************************
   // phases within one instruction cycle
   // ****************************************
   localparam int         PHASES     = 4;
   localparam logic [1:0] PH_DECODE  = 2'h0;
   localparam logic [1:0] PH_READ    = 2'h1;
   localparam logic [1:0] PH_EVAL    = 2'h2;
   localparam logic [1:0] PH_WRITE   = 2'h3;
   // reset values
   localparam logic [1:0] PHASE_RST  = 2'h0;
endpackage

// ==== design/btz_if.sv ====
/*
 * interface carrying phase timing from the phase divider to the executor.
 * assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface btz_phase_if;
   logic [1:0] phase;      // current phase number
   logic       cycle_end;  // pulse in the last phase of a cycle
   modport src (output phase, output cycle_end);
   modport dst (input phase, input cycle_end);
endinterface
`default_nettype wire

// ==== design/btz_phase_div.sv ====
/*
 * phase divider: splits the core clock into four-phase instruction cycles.
 * assumes synchronous active-low reset on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module btz_phase_div (
   // clock and reset
   input  wire logic     clk,
   input  wire logic     reset_n,
   // phase outputs
   btz_phase_if.src      ph
);
   typedef struct packed {
      logic [1:0] phase;
      logic       cycle_end;
   } btz_div_t;

   btz_div_t st_r;
   btz_div_t st_nxt;

   // ****************************************
   // phase counter
   // ****************************************
   always_comb begin
      st_nxt           = st_r;
      st_nxt.phase     = st_r.phase + 2'h1;
      st_nxt.cycle_end = (st_nxt.phase == btz_pkg::PH_WRITE);
   end

   // register the state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r.phase     <= btz_pkg::PHASE_RST;
         st_r.cycle_end <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ph.phase     = st_r.phase;
   assign ph.cycle_end = st_r.cycle_end;
endmodule
`default_nettype wire

// ==== design/btz_exec.sv ====
/*
 * execution block for the bit-test skip-when-zero instruction of an
 * 8-bit core: decode, banked operand read, bit test and skip control.
 * assumes the fetch pipeline presents the next instruction word on
 * INSTR_WORD at decode and reports whether the following fetched
 * instruction is two words long; data memory answers a read within the
 * phase in which the address is presented.
 * words offered while a test or its inserted cycles run are ignored
 * without any sign, so the fetch side must hold off until idle.
 * the status flags and data memory are never written.
 */
// Operation
// - a zero at the tested bit skips the next instruction, a one continues normally.
// - on a skip the fetched instruction is dropped and a no_operation cycle runs, two cycles in all.
// - when the skipped instruction has two words, two no_operation cycles follow, three cycles in all.
// - with the access bit at zero the fixed access bank is used and the bank_select_register ignored.
// - with the access bit at one, the default, the bank_select_register supplies the bank.
`timescale 1ns/1ps
`default_nettype none
module btz_exec (
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RESET_N,
   // instruction from the fetch pipeline
   input  wire logic [15:0] INSTR_WORD,
   input  wire logic        INSTR_VALID,
   input  wire logic        NEXT_TWO_WORD,
   // banking and data memory
   input  wire logic [3:0]  BANK_SELECT_REGISTER,
   input  wire logic [7:0]  MEM_RDATA,
   output logic     [11:0]  MEM_ADDR,
   output logic             MEM_RD,
   output logic             MEM_WR,
   // execution status
   output logic     [1:0]   PHASE,
   output logic             ACTIVE,
   output logic             NO_OPERATION,
   output logic             SKIP_TAKEN,
   output logic             FLAGS_WE
);
   // test cycle, then up to two inserted no_operation cycles
   typedef enum {S_IDLE, S_TEST, S_NOP1, S_NOP2} btz_state_t;

   // whole state of the executor in one register, except the phase counter kept in u_div
   typedef struct packed {
      btz_state_t  state;
      logic [2:0]  bit_idx;
      logic        two_word;
      logic [11:0] mem_addr;
      logic        mem_rd;
      logic        no_op;
      logic        skip;
      logic        active;
      logic [1:0]  phase;
   } btz_st_t;

   // state register, its next value and the phase carrier
   btz_st_t st_r;
   btz_st_t st_nxt;
   btz_phase_if ph ();

   // fields of the offered word
   logic [3:0] opc_field;
   logic [2:0] bit_field;
   logic       acc_field;
   logic [7:0] addr_field;
   // operand byte and per-lane bit test
   logic [7:0] rdata_byte;
   logic [7:0] bit_onehot;
   logic [7:0] bit_hits;
   logic       bit_is_zero;
   logic       is_match;

   // ****************************************
   // phase timing
   // ****************************************
   // four-phase cycle counted on the core clock
   btz_phase_div u_div (
      .clk     (CORE_CLK),
      .reset_n (RESET_N),
      .ph      (ph)
   );

   // ****************************************
   // field decode
   // ****************************************
   // word layout split
   assign opc_field  = INSTR_WORD[btz_pkg::OPC_MSB:btz_pkg::OPC_LSB];
   assign bit_field  = INSTR_WORD[btz_pkg::BIT_MSB:btz_pkg::BIT_LSB];
   assign acc_field  = INSTR_WORD[btz_pkg::ACC_POS];
   assign addr_field = INSTR_WORD[btz_pkg::ADDR_MSB:btz_pkg::ADDR_LSB];

   // opcode match
   // an unqualified word never starts a test, whatever it holds
   assign is_match = INSTR_VALID && (opc_field == btz_pkg::OPC_BIT_TEST_SKIP_WHEN_ZERO);

   // ****************************************
   // bit test
   // ****************************************
   // operand byte, only looked at in the read phase
   assign rdata_byte = MEM_RDATA;

   // one lane per bit
   // a lane hits when it is the selected bit and reads one
   generate
      for (genvar i = 0; i < 8; i++) begin : g_lane
         assign bit_onehot[i] = (st_r.bit_idx == 3'(i));
         assign bit_hits[i]   = bit_onehot[i] & rdata_byte[i];
      end
   endgenerate

   // selected bit is zero when no lane hits
   assign bit_is_zero = ~|bit_hits;

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      // hold by default, copy the phase, drop the strobe
      st_nxt        = st_r;
      st_nxt.phase  = ph.phase;
      st_nxt.mem_rd = 1'b0;
      case (st_r.state)
         S_IDLE: begin
            // clear the last result before a new test
            st_nxt.no_op = 1'b0;
            st_nxt.skip  = 1'b0;
            if (ph.phase == btz_pkg::PH_DECODE && is_match) begin
               st_nxt.state    = S_TEST;
               st_nxt.active   = 1'b1;
               st_nxt.bit_idx  = bit_field;
               st_nxt.two_word = NEXT_TWO_WORD;
               if (acc_field == btz_pkg::ACC_FIXED) begin
                  st_nxt.mem_addr = {btz_pkg::ACCESS_BANK, addr_field};
               end else begin
                  st_nxt.mem_addr = {BANK_SELECT_REGISTER, addr_field};
               end
               st_nxt.mem_rd = 1'b1;
            end else begin
               st_nxt.active = 1'b0;
            end
         end
         S_TEST: begin
            if (ph.phase == btz_pkg::PH_READ) begin
               st_nxt.skip = bit_is_zero;
            end
            if (ph.cycle_end) begin
               if (st_r.skip) begin
                  st_nxt.state = S_NOP1;
                  st_nxt.no_op = 1'b1;
               end else begin
                  st_nxt.state  = S_IDLE;
                  st_nxt.active = 1'b0;
               end
            end
         end
         S_NOP1: begin
            // an inserted cycle runs all four phases
            if (ph.cycle_end) begin
               if (st_r.two_word) begin
                  st_nxt.state = S_NOP2;
               end else begin
                  st_nxt.state  = S_IDLE;
                  st_nxt.no_op  = 1'b0;
                  st_nxt.active = 1'b0;
               end
            end
         end
         S_NOP2: begin
            if (ph.cycle_end) begin
               st_nxt.state  = S_IDLE;
               st_nxt.no_op  = 1'b0;
               st_nxt.active = 1'b0;
            end
         end
         default: begin
            // unused state codes fall back to idle
            st_nxt.state = S_IDLE;
         end
      endcase
   end

   // ****************************************
   // state register
   // ****************************************
   // synchronous reset leaves the executor idle with strobes low
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         // flags and address clear, phase copy at its reset value
         st_r       <= '0;
         st_r.state <= S_IDLE;
         st_r.phase <= btz_pkg::PHASE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // outputs straight from the state register, except MEM_WR and FLAGS_WE tied low
   assign MEM_ADDR     = st_r.mem_addr;
   assign MEM_RD       = st_r.mem_rd;
   assign MEM_WR       = 1'b0;  // block never writes memory
   assign PHASE        = st_r.phase;
   assign ACTIVE       = st_r.active;
   assign NO_OPERATION = st_r.no_op;
   assign SKIP_TAKEN   = st_r.skip;
   assign FLAGS_WE     = 1'b0;  // status flags untouched
endmodule
`default_nettype wire

// ==== bench/btz_asserts.sv ====
/* checker for the skip-when-zero executor.
   sees only the executor's ports; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module btz_asserts (
   // clock and reset
   input wire logic        CORE_CLK,
   input wire logic        RESET_N,
   // watched ports
   input wire logic [15:0] INSTR_WORD,
   input wire logic        INSTR_VALID,
   input wire logic        NEXT_TWO_WORD,
   input wire logic [3:0]  BANK_SELECT_REGISTER,
   input wire logic [7:0]  MEM_RDATA,
   input wire logic [11:0] MEM_ADDR,
   input wire logic        MEM_RD,
   input wire logic        MEM_WR,
   input wire logic        ACTIVE,
   input wire logic        NO_OPERATION,
   input wire logic        SKIP_TAKEN,
   input wire logic        FLAGS_WE
);
   logic       zero_r;
   logic       two_r;
   logic [3:0] nop_cnt_r;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // tested bit, length flag and run of no_operation clocks
   always_ff @(posedge CORE_CLK) begin
      if (MEM_RD) begin
         zero_r <= !MEM_RDATA[INSTR_WORD[11:9]];
         two_r  <= NEXT_TWO_WORD;
      end
      nop_cnt_r <= NO_OPERATION ? nop_cnt_r + 4'h1 : 4'h0;
   end
   // ****
   // properties
   // ****
   sequence rd_start; $rose(MEM_RD); endsequence
   sequence nop_cycle; NO_OPERATION [*4]; endsequence
   a_rd_pulse: assert property (rd_start |-> ACTIVE ##1 !MEM_RD)
      else $error("read strobe is not one pulse in an active cycle");
   a_opcode_match: assert property (rd_start |->
      $past(INSTR_VALID) && $past(INSTR_WORD[15:12]) == btz_pkg::OPC_BIT_TEST_SKIP_WHEN_ZERO)
      else $error("test started on a foreign opcode");
   a_bank_addr: assert property (rd_start |-> MEM_ADDR == {
      $past(INSTR_WORD[8]) ? $past(BANK_SELECT_REGISTER) : btz_pkg::ACCESS_BANK,
      $past(INSTR_WORD[7:0])})
      else $error("operand address has wrong bank or offset");
   a_skip_zero: assert property ($fell(MEM_RD) |=> SKIP_TAKEN == zero_r)
      else $error("skip result does not match tested bit");
   a_no_write: assert property (!MEM_WR && !FLAGS_WE)
      else $error("write or flag update seen");
   a_nop_skip: assert property ($rose(NO_OPERATION) |-> SKIP_TAKEN ##0 nop_cycle)
      else $error("no_operation cycle without skip or too short");
   a_nop_count: assert property ($fell(NO_OPERATION) |->
      nop_cnt_r == (two_r ? 4'h8 : 4'h4))
      else $error("wrong number of no_operation clocks");
   a_set_bit_idle: assert property ($fell(MEM_RD) ##1 !SKIP_TAKEN |->
      !NO_OPERATION ##[1:3] !ACTIVE)
      else $error("set bit did not end the test cycle");
endmodule
`default_nettype wire

// ==== bench/btz_mem_model.sv ====
/* data memory model on the far side of the executor.
   answers while the strobe is high and one cycle after. */
`timescale 1ns/1ps
`default_nettype none
module btz_mem_model (
   // clock
   input  wire logic        clk,
   // read port
   input  wire logic [11:0] addr,
   input  wire logic        rd,
   output logic      [7:0]  rdata
);
   logic [7:0] mem [4096];
   logic [7:0] q_r;
   logic       hold_r;
   // keep the byte for one cycle after the strobe
   always_ff @(posedge clk) begin
      hold_r <= rd;
      if (rd) begin
         q_r <= mem[addr];
      end
   end
   // outside the hold window the bus shows the inverse byte
   assign rdata = rd ? mem[addr] : (hold_r ? q_r : ~q_r);
endmodule
`default_nettype wire

// ==== bench/bit_test_skip_if_clear_tb.sv ====
/* self-checking bench for the skip-when-zero executor.
   inputs change at the falling edge; memory model on the far side. */
`timescale 1ns/1ps
`default_nettype none
module bit_test_skip_if_clear_tb;
   logic        CORE_CLK, RESET_N, INSTR_VALID, NEXT_TWO_WORD;
   logic [15:0] INSTR_WORD;
   logic [3:0]  BANK_SELECT_REGISTER;
   logic [7:0]  MEM_RDATA;
   logic [11:0] MEM_ADDR;
   logic [1:0]  PHASE;
   logic        MEM_RD, MEM_WR, ACTIVE, NO_OPERATION, SKIP_TAKEN, FLAGS_WE;
   int          miscompares = 0;
   int          comparisons = 0;
   int          cycles = 0;
   btz_exec i_dut (.CORE_CLK, .RESET_N, .INSTR_WORD, .INSTR_VALID, .NEXT_TWO_WORD,
      .BANK_SELECT_REGISTER, .MEM_RDATA, .MEM_ADDR, .MEM_RD, .MEM_WR, .PHASE,
      .ACTIVE, .NO_OPERATION, .SKIP_TAKEN, .FLAGS_WE);
   btz_mem_model i_mem (.clk(CORE_CLK), .addr(MEM_ADDR), .rd(MEM_RD), .rdata(MEM_RDATA));
   // clock and hang guard
   initial begin
      CORE_CLK = 1'b0;
      forever #2 CORE_CLK = ~CORE_CLK;
   end
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
   end
   // ****
   // expectations and checks
   // ****
   function automatic logic [11:0] exp_addr(input logic acc, input logic [3:0] bank_select_register,
                                            input logic [7:0] a);
      return {acc ? bank_select_register : btz_pkg::ACCESS_BANK, a};
   endfunction
   // clocks of inserted no_operation: one or two whole cycles on a skip
   function automatic logic [11:0] exp_nops(input logic zero, input logic two);
      return zero ? 12'(btz_pkg::PHASES * (two ? 2 : 1)) : 12'h0;
   endfunction
   // active clocks: rest of the test cycle after decode, then inserted cycles
   function automatic logic [11:0] exp_len(input logic zero, input logic two);
      return 12'(btz_pkg::PHASES - 1) + exp_nops(zero, two);
   endfunction
   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one instruction; the other bank holds the inverse byte
   task automatic run_test(input logic [3:0] op, input logic [2:0] b, input logic acc,
                           input logic two, input logic zero);
      logic [7:0] a;
      logic [7:0] v;
      logic [3:0] bank_select_register;
      int         na;
      int         nn;
      a = 8'($urandom);
      bank_select_register = 4'($urandom);
      if (bank_select_register == btz_pkg::ACCESS_BANK) bank_select_register = ~bank_select_register;
      v = 8'($urandom);
      v[b] = !zero;
      i_mem.mem[exp_addr(!acc, bank_select_register, a)] = ~v;
      i_mem.mem[exp_addr(acc, bank_select_register, a)] = v;
      @(negedge CORE_CLK);
      INSTR_WORD = {op, b, acc, a};
      INSTR_VALID = 1'b1;
      NEXT_TWO_WORD = two;
      BANK_SELECT_REGISTER = bank_select_register;
      na = 0;
      while (ACTIVE !== 1'b1 && na < 12) begin
         @(negedge CORE_CLK);
         na++;
      end
      INSTR_VALID = 1'b0;
      if (op != btz_pkg::OPC_BIT_TEST_SKIP_WHEN_ZERO) begin
         chk("refused", 12'h0, {11'h0, ACTIVE});
      end else begin
         chk("mem_addr", exp_addr(acc, bank_select_register, a), MEM_ADDR);
         na = 0;
         nn = 0;
         while (ACTIVE === 1'b1 && na < 16) begin
            if (na == 0) chk("mem_rd_on", 12'h1, {11'h0, MEM_RD});
            if (na == 1) chk("mem_rd", 12'h0, {11'h0, MEM_RD});
            chk("phase", 12'(na % btz_pkg::PHASES), {10'h0, PHASE});
            if (na == 2) chk("skip", {11'h0, zero}, {11'h0, SKIP_TAKEN});
            na++;
            nn += int'(NO_OPERATION === 1'b1);
            @(negedge CORE_CLK);
         end
         chk("active_len", exp_len(zero, two), 12'(na));
         chk("nop_len", exp_nops(zero, two), 12'(nn));
      end
      $display("test done op %h bit %0d access %0d", op, b, acc);
   endtask
   // reset, corner cases, then random instructions
   initial begin
      RESET_N = 1'b0;
      INSTR_WORD = 16'h0000;
      INSTR_VALID = 1'b0;
      NEXT_TWO_WORD = 1'b0;
      BANK_SELECT_REGISTER = 4'h0;
      void'($urandom(17923));
      repeat (3) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
      RESET_N = 1'b1;
      run_test(btz_pkg::OPC_BIT_TEST_SKIP_WHEN_ZERO, 3'h0, 1'h0, 1'h0, 1'h1);
      run_test(btz_pkg::OPC_BIT_TEST_SKIP_WHEN_ZERO, 3'h7, 1'h1, 1'h1, 1'h0);
      run_test(btz_pkg::OPC_BIT_TEST_SKIP_WHEN_ZERO, 3'h3, 1'h1, 1'h1, 1'h1);
      run_test(4'ha, 3'h1, 1'h1, 1'h0, 1'h1);
      repeat (24) run_test(btz_pkg::OPC_BIT_TEST_SKIP_WHEN_ZERO, 3'($urandom),
         1'($urandom), 1'($urandom), 1'($urandom));
      complete_run();
   end
endmodule
bind btz_exec btz_asserts i_chk (.CORE_CLK, .RESET_N, .INSTR_WORD, .INSTR_VALID, .NEXT_TWO_WORD,
   .BANK_SELECT_REGISTER, .MEM_RDATA, .MEM_ADDR, .MEM_RD, .MEM_WR, .ACTIVE,
   .NO_OPERATION, .SKIP_TAKEN, .FLAGS_WE);
`default_nettype wire
